/* File: dcs_pkg.sv */
// Package for the driver command and status bank: bit positions, timing and carrier types.
// Assumes one 200 MHz core clock and a serial link sampled synchronously to it.
package dcs_pkg;

   // Frame length and bit positions of command word zero.
   localparam int unsigned FRAME_BITS = 24;
   localparam logic [4:0] FRAME_BITS_CNT = 5'h18;
   localparam logic [4:0] CNT_SAT = 5'h19;
   localparam int unsigned BIT_SELECT = 0;
   localparam int unsigned BIT_ENABLE = 23;
   localparam int unsigned BIT_STATUS_CLEAR = 22;
   localparam int unsigned BIT_RECOV_DUTY = 21;
   localparam int unsigned BIT_SUPPLY_REC_DIS = 20;
   localparam int unsigned BIT_MON_HI = 19;
   localparam int unsigned BIT_MON_LO = 18;
   localparam int unsigned BIT_DRV_LO = 1;
   localparam int unsigned BIT_DRV_HI = 17;
   localparam int unsigned DRV_COUNT = 17;
   localparam int unsigned BIT_HALFBRIDGE_OUT_ONE_HS = 2;
   localparam int unsigned BIT_HALFBRIDGE_OUT_SIX_HS = 12;

   // Bit positions of status word zero.
   localparam int unsigned ST_ALWAYS_ONE = 23;
   localparam int unsigned ST_OVERVOLT = 22;
   localparam int unsigned ST_UNDERVOLT = 21;
   localparam int unsigned ST_THERMAL = 20;
   localparam int unsigned ST_TEMP_WARN = 19;
   localparam int unsigned ST_NOT_READY = 18;
   localparam int unsigned ST_NO_ERROR = 0;

   // Reset values.
   localparam logic [23:0] WORD_RESET = 24'h000000;

   // Monitor select codes (bit 19, bit 18).
   localparam logic [1:0] MON_SEL_HIGHSIDE_OUT_ELEVEN = 2'h0;
   localparam logic [1:0] MON_SEL_HALFBRIDGE_OUT_FIVE = 2'h1;
   localparam logic [1:0] MON_SEL_HALFBRIDGE_OUT_ONE_6 = 2'h2;
   localparam logic [1:0] MON_SEL_HALFBRIDGE_OUT_FOUR = 2'h3;

   // Start-up settling time and its cycle count at 200 MHz.
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned SETTLE_TIME_US = 100;
   localparam int unsigned SETTLE_CYCLES =
      (SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Over-current recovery pulse on-times in cycles, out of a 256-cycle period.
   localparam logic [7:0] RECOV_ON_LOW = 8'h20;
   localparam logic [7:0] RECOV_ON_HIGH = 8'h40;

   // Device operating states, one-hot.
   typedef enum logic [2:0] {
      DCS_STANDBY = 3'h1,
      DCS_SETTLING = 3'h2,
      DCS_ACTIVE = 3'h4
   } dcs_state_t;

   // Analogue fault comparators seen by the logic.
   typedef struct packed {
      logic overvoltage;
      logic undervoltage;
      logic thermal_shutdown;
      logic temp_warning;
   } dcs_fault_t;

   // Current monitor route, one-hot over the monitored drivers.
   typedef struct packed {
      logic highside_out_eleven;
      logic halfbridge_out_one;
      logic halfbridge_out_six;
      logic halfbridge_out_five;
      logic halfbridge_out_four;
   } dcs_monitor_t;

endpackage : dcs_pkg

/* File: dcs_bank.sv */
// Command and status register pair zero with its serial link, supply and thermal
// fault handling, start-up timer and current monitor routing.
// Assumes link pins are already synchronous to core_clk_in and fault inputs are levels.
//
// Notes on behaviour
// - Undervoltage sets its flag and drops outputs, which return by themselves on recovery.
// - With recovery disable set, a supply fault keeps outputs off until the status is cleared.
// - Thermal shutdown sets its flag and keeps outputs off until the status-clear bit clears it.
// - Temperature warning shows in status bit 19, clears the no-error bit and gates no output.
// - Command bits 19 and 18 route the current monitor to out 11, 5, 1 or 6, or 4 for codes 0 to 3.
// - In the 1/6 selection, out 1 is monitored only if its high side is on and out 6's is off.
// - Leaving standby starts the settling timer, holds outputs off and sets not-ready.
// - Not-ready clears by itself when the internal timer expires.
// - A word is committed at chip select rising only after exactly 24 clocks.
// - The first received bit picks the command register written and the status word shifted out after bit 0.
// - Writing status-clear as one clears both status words at the end of the frame.
// - Enable bit zero enters standby and clears all bits; reset starts in standby.
`timescale 1ns/10ps
`default_nettype none
module dcs_bank
   import dcs_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic chip_select_low_in,
   input wire logic spi_clk_in,
   input wire logic spi_data_in,
   output logic spi_data_out,
   output logic spi_data_oe_out,
   input wire dcs_fault_t fault_in,
   input wire logic [16:0] overcurrent_in,
   input wire logic [23:0] status_word_one_in,
   output logic [16:0] driver_on_out,
   output logic outputs_allowed_out,
   output dcs_monitor_t current_monitor_output,
   output logic recovery_gate_out,
   output logic [23:0] command_word_one_out,
   output logic status_clear_out,
   output logic not_ready_out
);

   localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES_P - 1);

   logic csn_prev_reg;
   logic sclk_prev_reg;
   logic [4:0] bit_cnt_reg;
   logic [23:0] shift_reg;
   logic [23:0] snap0_reg;
   logic [23:0] snap1_reg;
   logic [23:0] command_word_zero;
   logic [23:0] fault_status_word_zero;
   logic [16:0] oc_flag_reg;
   logic ov_flag_reg;
   logic uv_flag_reg;
   logic tsd_flag_reg;
   logic warn_flag_reg;
   dcs_state_t state_reg;
   logic [15:0] settle_cnt_reg;
   logic [7:0] recov_phase_reg;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic commit;
   logic commit0;
   logic go_standby;
   logic status_clr;
   logic allow;
   logic [1:0] mon_sel;

   // Edge detection on the link pins.
   assign cs_fall = csn_prev_reg & ~chip_select_low_in;
   assign cs_rise = ~csn_prev_reg & chip_select_low_in;
   assign sclk_rise = ~chip_select_low_in & ~sclk_prev_reg & spi_clk_in;
   assign sclk_fall = ~chip_select_low_in & sclk_prev_reg & ~spi_clk_in;
   assign commit = cs_rise & (bit_cnt_reg == FRAME_BITS_CNT);
   assign commit0 = commit & ~shift_reg[BIT_SELECT];
   assign go_standby = commit0 & ~shift_reg[BIT_ENABLE];
   assign status_clr = commit0 & shift_reg[BIT_STATUS_CLEAR];

   // Pin history for edge detection.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         csn_prev_reg <= 1'h1;
         sclk_prev_reg <= 1'h0;
      end
      else
      begin
         csn_prev_reg <= chip_select_low_in;
         sclk_prev_reg <= spi_clk_in;
      end
   end

   // Input shifting: bit 0 arrives first, sampled on serial clock rising.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bit_cnt_reg <= 5'h00;
         shift_reg <= WORD_RESET;
      end
      else if (cs_fall)
      begin
         bit_cnt_reg <= 5'h00;
         shift_reg <= WORD_RESET;
      end
      else if (sclk_rise)
      begin
         if (bit_cnt_reg < FRAME_BITS_CNT)
         begin
            shift_reg[bit_cnt_reg] <= spi_data_in;
         end
         if (bit_cnt_reg != CNT_SAT)
         begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // Status snapshot at frame start and output shifting on serial clock falling.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         snap0_reg <= WORD_RESET;
         snap1_reg <= WORD_RESET;
         spi_data_out <= 1'h0;
         spi_data_oe_out <= 1'h0;
      end
      else
      begin
         spi_data_oe_out <= ~chip_select_low_in;
         if (cs_fall)
         begin
            snap0_reg <= fault_status_word_zero;
            snap1_reg <= status_word_one_in;
            spi_data_out <= fault_status_word_zero[ST_NO_ERROR];
         end
         else if (sclk_fall)
         begin
            if (bit_cnt_reg < FRAME_BITS_CNT)
            begin
               spi_data_out <= shift_reg[BIT_SELECT] ? snap1_reg[bit_cnt_reg]
                                                     : snap0_reg[bit_cnt_reg];
            end
            else
            begin
               spi_data_out <= 1'h0;
            end
         end
      end
   end

   // Command registers, written only on a complete frame.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         command_word_zero <= WORD_RESET;
         command_word_one_out <= WORD_RESET;
         status_clear_out <= 1'h0;
      end
      else
      begin
         status_clear_out <= status_clr | go_standby;
         if (go_standby)
         begin
            command_word_zero <= WORD_RESET;
            command_word_one_out <= WORD_RESET;
         end
         else if (commit0)
         begin
            command_word_zero <= shift_reg;
         end
         else if (commit)
         begin
            command_word_one_out <= shift_reg;
         end
      end
   end

   // Operating state and start-up settling timer.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= DCS_STANDBY;
         settle_cnt_reg <= 16'h0000;
      end
      else
      begin
         unique case (state_reg)
            DCS_STANDBY:
            begin
               settle_cnt_reg <= 16'h0000;
               if (command_word_zero[BIT_ENABLE])
               begin
                  state_reg <= DCS_SETTLING;
               end
            end
            DCS_SETTLING:
            begin
               settle_cnt_reg <= settle_cnt_reg + 16'h0001;
               if (!command_word_zero[BIT_ENABLE])
               begin
                  state_reg <= DCS_STANDBY;
               end
               else if (settle_cnt_reg >= SETTLE_LAST)
               begin
                  state_reg <= DCS_ACTIVE;
               end
            end
            DCS_ACTIVE:
            begin
               if (!command_word_zero[BIT_ENABLE])
               begin
                  state_reg <= DCS_STANDBY;
               end
            end
         endcase
      end
   end

   // Sticky fault flags: an event wins over a clear in the same cycle.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ov_flag_reg <= 1'h0;
         uv_flag_reg <= 1'h0;
         tsd_flag_reg <= 1'h0;
         warn_flag_reg <= 1'h0;
      end
      else if (state_reg == DCS_STANDBY)
      begin
         ov_flag_reg <= 1'h0;
         uv_flag_reg <= 1'h0;
         tsd_flag_reg <= 1'h0;
         warn_flag_reg <= 1'h0;
      end
      else
      begin
         ov_flag_reg <= (ov_flag_reg & ~status_clr) | fault_in.overvoltage;
         uv_flag_reg <= (uv_flag_reg & ~status_clr) | fault_in.undervoltage;
         tsd_flag_reg <= (tsd_flag_reg & ~status_clr) | fault_in.thermal_shutdown;
         warn_flag_reg <= (warn_flag_reg & ~status_clr) | fault_in.temp_warning;
      end
   end

   // Per-driver over-current flags.
   genvar gi;
   generate
      for (gi = 0; gi < DRV_COUNT; gi++)
      begin : g_oc
         always_ff @(posedge core_clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               oc_flag_reg[gi] <= 1'h0;
            end
            else if (state_reg == DCS_STANDBY)
            begin
               oc_flag_reg[gi] <= 1'h0;
            end
            else
            begin
               oc_flag_reg[gi] <= (oc_flag_reg[gi] & ~status_clr) | overcurrent_in[gi];
            end
         end
      end
   endgenerate

   // Status word zero as read over the link.
   always_comb
   begin
      fault_status_word_zero = WORD_RESET;
      fault_status_word_zero[ST_ALWAYS_ONE] = 1'h1;
      fault_status_word_zero[ST_OVERVOLT] = ov_flag_reg;
      fault_status_word_zero[ST_UNDERVOLT] = uv_flag_reg;
      fault_status_word_zero[ST_THERMAL] = tsd_flag_reg;
      fault_status_word_zero[ST_TEMP_WARN] = warn_flag_reg;
      fault_status_word_zero[ST_NOT_READY] = (state_reg == DCS_SETTLING);
      fault_status_word_zero[BIT_DRV_HI:BIT_DRV_LO] = oc_flag_reg;
      fault_status_word_zero[ST_NO_ERROR] =
         ~(|fault_status_word_zero[ST_OVERVOLT:BIT_DRV_LO]
           | |status_word_one_in[ST_OVERVOLT:BIT_DRV_LO]);
   end

   // Output permission: active, supply good, no latched thermal or locked supply fault.
   assign allow = (state_reg == DCS_ACTIVE)
                  & ~fault_in.undervoltage & ~fault_in.overvoltage
                  & ~tsd_flag_reg
                  & ~(command_word_zero[BIT_SUPPLY_REC_DIS]
                      & (uv_flag_reg | ov_flag_reg));
   assign mon_sel = {command_word_zero[BIT_MON_HI], command_word_zero[BIT_MON_LO]};

   // Driver commands and monitor routing.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         driver_on_out <= 17'h00000;
         outputs_allowed_out <= 1'h0;
         current_monitor_output <= '0;
         not_ready_out <= 1'h0;
      end
      else
      begin
         driver_on_out <= allow ? command_word_zero[BIT_DRV_HI:BIT_DRV_LO] : 17'h00000;
         outputs_allowed_out <= allow;
         not_ready_out <= (state_reg == DCS_SETTLING);
         current_monitor_output <= '0;
         unique case (mon_sel)
            MON_SEL_HIGHSIDE_OUT_ELEVEN: current_monitor_output.highside_out_eleven <= 1'h1;
            MON_SEL_HALFBRIDGE_OUT_FIVE: current_monitor_output.halfbridge_out_five <= 1'h1;
            MON_SEL_HALFBRIDGE_OUT_FOUR: current_monitor_output.halfbridge_out_four <= 1'h1;
            MON_SEL_HALFBRIDGE_OUT_ONE_6:
            begin
               if (command_word_zero[BIT_HALFBRIDGE_OUT_ONE_HS] && !command_word_zero[BIT_HALFBRIDGE_OUT_SIX_HS])
               begin
                  current_monitor_output.halfbridge_out_one <= 1'h1;
               end
               else
               begin
                  current_monitor_output.halfbridge_out_six <= 1'h1;
               end
            end
         endcase
      end
   end

   // Over-current recovery pulse gate with selectable on-time.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         recov_phase_reg <= 8'h00;
         recovery_gate_out <= 1'h0;
      end
      else
      begin
         recov_phase_reg <= recov_phase_reg + 8'h01;
         recovery_gate_out <= command_word_zero[BIT_RECOV_DUTY]
                              ? (recov_phase_reg < RECOV_ON_HIGH)
                              : (recov_phase_reg < RECOV_ON_LOW);
      end
   end

endmodule : dcs_bank
`default_nettype wire

/* File: dcs_host.sv */
// Host model that frames command words to the bank over the serial link.
// Assumes it shares the core clock; the serial clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none
module dcs_host
(
   input wire logic clk_in,
   input wire logic miso_in,
   output var logic cs_n_out,
   output var logic sclk_out,
   output var logic mosi_out
);
   // The link starts idle: select high and clock low.
   initial
   begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
   end

   // Waits n core cycles, then steps just past the edge.
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step

   // Shifts nb bits out LSB first and collects the answer bit at each rise.
   task automatic xfer(input logic [23:0] tx, input int nb, output logic [23:0] rx);
      rx = 24'h000000;
      cs_n_out = 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         mosi_out = tx[i];
         step(3);
         rx[i] = miso_in;
         sclk_out = 1'b1;
         step(3);
         sclk_out = 1'b0;
      end
      step(3);
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
      step(4);
   endtask : xfer
endmodule : dcs_host
`default_nettype wire

/* File: dcs_bank_assertions.sv */
// Checker for the command and status bank, bound into every dcs_bank.
// Assumes chip select stays high for several cycles after each frame.
`timescale 1ns/10ps
`default_nettype none
module dcs_chk
   import dcs_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES_P = 8
)
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic chip_select_low_in,
   input wire logic spi_clk_in,
   input wire logic spi_data_in,
   input wire logic spi_data_out,
   input wire logic spi_data_oe_out,
   input wire dcs_fault_t fault_in,
   input wire logic [16:0] overcurrent_in,
   input wire logic [23:0] status_word_one_in,
   input wire logic [16:0] driver_on_out,
   input wire logic outputs_allowed_out,
   input wire dcs_monitor_t current_monitor_output,
   input wire logic recovery_gate_out,
   input wire logic [23:0] command_word_one_out,
   input wire logic status_clear_out,
   input wire logic not_ready_out
);
   logic [15:0] nr_cnt;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Counts how long the current not-ready run has lasted.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         nr_cnt <= 16'h0000;
      else
         nr_cnt <= not_ready_out ? nr_cnt + 16'h0001 : 16'h0000;
   end

   // Link timing, settling time, output gating and monitor routing.
   a_oe_tracks_select: assert property (spi_data_oe_out == !$past(chip_select_low_in))
      else $error("data enable does not follow select");
   a_drivers_gated: assert property (!outputs_allowed_out && !$past(outputs_allowed_out) |-> driver_on_out == 17'h00000)
      else $error("driver on while outputs barred");
   a_ready_blocks: assert property (not_ready_out && $past(not_ready_out) |-> !outputs_allowed_out)
      else $error("outputs allowed while not ready");
   a_settle_bounded: assert property (nr_cnt <= SETTLE_CYCLES_P + 1)
      else $error("not ready lasts too long");
   a_clear_single: assert property (status_clear_out |=> !status_clear_out)
      else $error("status clear longer than one cycle");
   a_clear_after_frame: assert property (status_clear_out |-> chip_select_low_in && !spi_data_oe_out)
      else $error("status clear inside a frame");
   a_monitor_onehot: assert property ($onehot0(current_monitor_output))
      else $error("monitor route not one-hot");
   a_monitor_out_one: assert property (current_monitor_output.halfbridge_out_one && outputs_allowed_out && $past(outputs_allowed_out) |-> driver_on_out[1] && !driver_on_out[11])
      else $error("out one monitored wrongly");
endmodule : dcs_chk
bind dcs_bank dcs_chk #(.SETTLE_CYCLES_P(SETTLE_CYCLES_P)) chk_u (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .chip_select_low_in(chip_select_low_in), .spi_clk_in(spi_clk_in),
   .spi_data_in(spi_data_in), .spi_data_out(spi_data_out), .spi_data_oe_out(spi_data_oe_out),
   .fault_in(fault_in), .overcurrent_in(overcurrent_in), .status_word_one_in(status_word_one_in),
   .driver_on_out(driver_on_out), .outputs_allowed_out(outputs_allowed_out),
   .current_monitor_output(current_monitor_output), .recovery_gate_out(recovery_gate_out),
   .command_word_one_out(command_word_one_out), .status_clear_out(status_clear_out),
   .not_ready_out(not_ready_out));
`default_nettype wire

/* File: tb.sv */
// Testbench for the command and status bank: link, start-up, faults and recovery gate.
// Assumes the host model drives the link and settling is shortened to 40 cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
   import dcs_pkg::*;
;
   logic clk, rst_n, cs_n, sclk, mosi, miso, oe, allowed, gate, clr, nrdy;
   logic [16:0] oc, drv;
   logic [23:0] st1, cw1, rx;
   dcs_fault_t flt;
   dcs_monitor_t mon;
   int n_mismatch = 0;
   int cmp_count = 0;
   int clr_seen = 0;
   dcs_bank #(.SETTLE_CYCLES_P(40)) dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
      .chip_select_low_in(cs_n), .spi_clk_in(sclk), .spi_data_in(mosi), .spi_data_out(miso),
      .spi_data_oe_out(oe), .fault_in(flt), .overcurrent_in(oc), .status_word_one_in(st1),
      .driver_on_out(drv), .outputs_allowed_out(allowed), .current_monitor_output(mon),
      .recovery_gate_out(gate), .command_word_one_out(cw1), .status_clear_out(clr),
      .not_ready_out(nrdy));
   dcs_host host_u (.clk_in(clk), .miso_in(miso), .cs_n_out(cs_n), .sclk_out(sclk),
      .mosi_out(mosi));

   // Core clock, and a count of status-clear pulses.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
      if (clr === 1'b1) clr_seen++;

   // One full frame to command word zero; the answer lands in rx.
   task automatic wr(input logic [23:0] w);
      host_u.xfer(w, 24, rx);
   endtask : wr

   // Standby after reset, register select, short frame and standby commit.
   task automatic t_link();
      int n;
      wr(24'h000000);
      `CHK({rx, allowed}, 25'h1000002)
      host_u.xfer(24'h5A5A5B, 24, rx);
      `CHK({rx, cw1}, {st1[23:1], 1'b1, 24'h5A5A5B})
      host_u.xfer(24'h000001, 23, rx);
      `CHK(cw1, 24'h5A5A5B)
      // Walks one fault bit through status word one; bit 0 is always the shared no-error bit.
      for (int k = 1; k < 23; k += 7)
      begin
         st1 = 24'h800000 | (24'h000001 << k);
         host_u.xfer(24'h5A5A5B, 24, rx);
         `CHK(rx, {st1[23:1], 1'b0})
      end
      st1 = 24'h800000;
      n = clr_seen;
      wr(24'h000000);
      `CHK({cw1, clr_seen - n}, {24'h000000, 32'h1})
      $display("test link done");
   endtask : t_link

   // Settling after enable, then every monitor route.
   task automatic t_start();
      logic [4:0] exp [4] = '{5'h10, 5'h02, 5'h08, 5'h01};
      wr(24'h800000);
      `CHK({nrdy, allowed}, 2'b10)
      wr(24'h800000);
      `CHK({rx[18], nrdy, allowed}, 3'b101)
      for (int c = 0; c < 4; c++)
      begin
         wr({4'h8, c[1:0], 18'h00004});
         `CHK({mon, drv}, {exp[c], 17'h00002})
      end
      `CHK(rx, 24'h800001)
      wr(24'h881004);
      `CHK(mon, 5'h04)
      $display("test start done");
   endtask : t_start

   // Supply and thermal faults, warning, over-current and status clear.
   task automatic t_faults();
      flt.undervoltage = 1'b1;
      host_u.step(2);
      wr(24'h800004);
      `CHK({rx[21], allowed}, 2'b10)
      flt = '0;
      host_u.step(3);
      `CHK(allowed, 1'b1)
      wr(24'hD00004);
      flt.overvoltage = 1'b1;
      host_u.step(3);
      flt = '0;
      host_u.step(3);
      `CHK(allowed, 1'b0)
      wr(24'hC00004);
      `CHK(allowed, 1'b1)
      flt.thermal_shutdown = 1'b1;
      host_u.step(3);
      flt = '0;
      wr(24'h800004);
      `CHK({rx[20], allowed}, 2'b10)
      wr(24'hC00004);
      `CHK(allowed, 1'b1)
      flt.temp_warning = 1'b1;
      oc = 17'h00001;
      host_u.step(2);
      wr(24'h800004);
      `CHK({rx[19], rx[1:0], allowed}, 4'b1101)
      flt = '0;
      oc = 17'h00000;
      wr(24'hC00004);
      wr(24'h800004);
      `CHK(rx, 24'h800001)
      // Over-current flags 0, 8 and 16 each show alone because the clear before each emptied the word.
      for (int k = 0; k < 17; k += 8)
      begin
         oc = 17'h00001 << k;
         host_u.step(2);
         oc = 17'h00000;
         wr(24'h800004);
         `CHK(rx, 24'h800000 | (24'h000002 << k))
         wr(24'hC00004);
      end
      $display("test faults done");
   endtask : t_faults

   // Recovery gate on-time over one 256-cycle period for both duty settings.
   task automatic t_duty();
      int n;
      for (int d = 0; d < 2; d++)
      begin
         wr({2'h2, d[0], 21'h000004});
         n = 0;
         repeat (256)
         begin
            host_u.step(1);
            n += (gate === 1'b1);
         end
         `CHK(n, 32 << d)
      end
      $display("test duty done");
   endtask : t_duty

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // Main sequence.
   initial
   begin
      rst_n = 1'b0;
      flt = '0;
      oc = 17'h00000;
      st1 = 24'h800000;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      host_u.step(2);
      t_link();
      t_start();
      t_faults();
      t_duty();
      finish_test();
   end

   // Watchdog against a hang.
   initial
   begin
      #60000;
      n_mismatch++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
